// File: crn_reset_nmi_map.vh
// Register map and field constants of the reset-cause and NMI register bank.
// Assumes a word-addressed plain register port with byte addresses.
`ifndef CRN_RESET_NMI_MAP_VH
`define CRN_RESET_NMI_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CRN_ADDR_W 8
`define CRN_OFF_REQ_CLEAR 8'h00
`define CRN_OFF_RESET_CAUSE 8'h04
`define CRN_OFF_NMI_SOURCE 8'h08
`define CRN_OFF_IRQ_STATUS 8'h0c
`define CRN_OFF_IRQ_MASK 8'h10

// ----------------------------------------------------------------------
// Request-clear field
// ----------------------------------------------------------------------
`define CRN_REQ_CODE_W 5
`define CRN_REQ_CODE_LAST 5'h05
`define CRN_WAKE_CNT 6

// ----------------------------------------------------------------------
// Reset-cause bit positions and power-on value
// ----------------------------------------------------------------------
`define CRN_RC_POWERON 0
`define CRN_RC_PIN 1
`define CRN_RC_WATCHDOG 2
`define CRN_RC_SOFT 4
`define CRN_RC_LOWVOLT 6
`define CRN_RC_W 7
`define CRN_RC_IMPL_MASK 7'h57
`define CRN_RC_POR_VALUE 7'h01

// ----------------------------------------------------------------------
// NMI source bit positions
// ----------------------------------------------------------------------
`define CRN_NMI_WATCHDOG 0
`define CRN_NMI_LV_DROP 2
`define CRN_NMI_LV_RECOVER 3
`define CRN_NMI_W 4

// ----------------------------------------------------------------------
// Interrupt status and mask layout
// ----------------------------------------------------------------------
`define CRN_IRQ_W 9
`define CRN_IRQ_NMI_WATCHDOG 6
`define CRN_IRQ_NMI_LV_DROP 7
`define CRN_IRQ_NMI_LV_RECOVER 8
`define CRN_IRQ_MASK_RESET 9'h000

// ----------------------------------------------------------------------
// Active-level modes and captured edge status codes
// ----------------------------------------------------------------------
`define CRN_MODE_LOW 3'h0
`define CRN_MODE_HIGH 3'h1
`define CRN_MODE_FALL 3'h2
`define CRN_MODE_RISE 3'h3
`define CRN_MODE_BOTH 3'h4
`define CRN_EDGE_RISE 2'h1
`define CRN_EDGE_FALL 2'h2

`endif

// File: crn_sync3.v
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the inputs are asynchronous to clk; one lane per bit.
`timescale 1ns/1ps

module crn_sync3 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // The first stage feeds only the second, so metastability never
      // reaches the filter.
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level_out[i] = lvl_q;
    end
  endgenerate

endmodule // crn_sync3

// File: crn_wake_chan.v
// One external standby-release channel: request detection and edge status.
// Assumes a filtered pin level and a one-cycle clear pulse on clk.
`timescale 1ns/1ps
`include "crn_reset_nmi_map.vh"

module crn_wake_chan (
  input wire clk,
  input wire arst_n,
  input wire pin_level,
  input wire enable,
  input wire [2:0] mode,
  input wire clear,
  output wire pending,
  output wire [1:0] edge_status
);

  reg prev_q;
  reg pend_q;
  reg [1:0] edge_q;
  reg hit;
  reg [1:0] edge_now;
  wire rise = pin_level & ~prev_q;
  wire fall = ~pin_level & prev_q;

  always @* begin
    hit = 1'b0;
    edge_now = 2'h0;
    case (mode)
      `CRN_MODE_LOW: hit = ~pin_level;
      `CRN_MODE_HIGH: hit = pin_level;
      `CRN_MODE_FALL: hit = fall;
      `CRN_MODE_RISE: hit = rise;
      `CRN_MODE_BOTH: begin
        hit = rise | fall;
        edge_now = (rise ? `CRN_EDGE_RISE : 2'h0) |
                   (fall ? `CRN_EDGE_FALL : 2'h0);
      end
      default: hit = 1'b0;
    endcase
    hit = hit & enable;
  end

  // A new request in the clear cycle survives the clear.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
      edge_q <= 2'h0;
    end else begin
      prev_q <= pin_level;
      if (hit) begin
        pend_q <= 1'b1;
      end else if (clear) begin
        pend_q <= 1'b0;
      end
      if (hit) begin
        edge_q <= (clear ? 2'h0 : edge_q) | edge_now;
      end else if (clear) begin
        edge_q <= 2'h0;
      end
    end
  end

  assign pending = pend_q;
  assign edge_status = edge_q;

endmodule // crn_wake_chan

// File: crn_reset_nmi_regs.v
// Reset-cause, NMI-source and standby-release request-clear registers.
// Assumes arst_n is the power-on reset only; other reset causes arrive as
// one-cycle event pulses from the reset controller on clk, while the
// reset pin and the six external interrupt pins are asynchronous.
`timescale 1ns/1ps
`include "crn_reset_nmi_map.vh"

// Notes on behaviour
// - Code 0..5 clears that input's standby request.
// - Clearing a request also clears its edge status.
// - Bit 6 flags a low-voltage reset.
// - Bit 4 flags a software system reset.
// - Bit 2 flags a watchdog reset.
// - Bit 1 flags a reset pin reset.
// - Bit 0 set at power-on; bits 3 and 5 reserved zero.
// - Writing zero clears a flag, one keeps.
// - Reset-cause flags never clear by themselves.
// - NMI bit 3 flags low-voltage recovery.
// - NMI bit 2 flags supply below threshold.
// - NMI bit 0 flags a watchdog NMI.
module crn_reset_nmi_regs (
  input wire clk,
  input wire arst_n,
  input wire [`CRN_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire reset_pin_n,
  input wire watchdog_reset_evt,
  input wire lowvolt_reset_evt,
  input wire soft_sysreset_evt,
  input wire nmi_watchdog_evt,
  input wire nmi_lowvolt_drop_evt,
  input wire nmi_lowvolt_recover_evt,
  input wire [`CRN_WAKE_CNT-1:0] ext_int_pin,
  input wire [`CRN_WAKE_CNT-1:0] ext_int_enable,
  input wire [3*`CRN_WAKE_CNT-1:0] ext_int_mode,
  output wire [`CRN_WAKE_CNT-1:0] wake_pending,
  output wire [2*`CRN_WAKE_CNT-1:0] captured_edge_status,
  output wire standby_release,
  output wire irq
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  wire [`CRN_WAKE_CNT:0] pin_level;
  wire reset_pin_level_n;
  wire [`CRN_WAKE_CNT-1:0] int_level;

  crn_sync3 #(
    .WIDTH(`CRN_WAKE_CNT + 1)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in({reset_pin_n, ext_int_pin}),
    .level_out(pin_level)
  );

  assign reset_pin_level_n = pin_level[`CRN_WAKE_CNT];
  assign int_level = pin_level[`CRN_WAKE_CNT-1:0];

  // ----------------------------------------------------------------------
  // Reset pin event
  // ----------------------------------------------------------------------
  // The filtered pin powers up low, which would look like a pin reset
  // right after power-on; the pin is only watched once it was seen high.
  reg pin_armed_q;
  reg pin_prev_n_q;
  wire pin_reset_evt;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_armed_q <= 1'b0;
      pin_prev_n_q <= 1'b0;
    end else begin
      pin_prev_n_q <= reset_pin_level_n;
      if (reset_pin_level_n) begin
        pin_armed_q <= 1'b1;
      end
    end
  end

  assign pin_reset_evt = pin_armed_q & pin_prev_n_q & ~reset_pin_level_n;

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  reg sel_req_clear;
  reg sel_reset_cause;
  reg sel_nmi_source;
  reg sel_irq_status;
  reg sel_irq_mask;

  // Exact decode: an address off the map selects nothing, so a stray
  // write is dropped and a stray read returns zero.
  always @* begin
    sel_req_clear = 1'b0;
    sel_reset_cause = 1'b0;
    sel_nmi_source = 1'b0;
    sel_irq_status = 1'b0;
    sel_irq_mask = 1'b0;
    case (reg_addr)
      `CRN_OFF_REQ_CLEAR: sel_req_clear = 1'b1;
      `CRN_OFF_RESET_CAUSE: sel_reset_cause = 1'b1;
      `CRN_OFF_NMI_SOURCE: sel_nmi_source = 1'b1;
      `CRN_OFF_IRQ_STATUS: sel_irq_status = 1'b1;
      `CRN_OFF_IRQ_MASK: sel_irq_mask = 1'b1;
      default: sel_req_clear = 1'b0;
    endcase
  end

  wire wr_req_clear = reg_wr & sel_req_clear;
  wire wr_reset_cause = reg_wr & sel_reset_cause;
  wire wr_irq_status = reg_wr & sel_irq_status;
  wire wr_irq_mask = reg_wr & sel_irq_mask;
  wire rd_nmi_source = reg_rd & sel_nmi_source;

  // ----------------------------------------------------------------------
  // Standby-release request clear
  // ----------------------------------------------------------------------
  wire [`CRN_REQ_CODE_W-1:0] req_code;
  wire req_code_ok;
  reg [`CRN_WAKE_CNT-1:0] chan_clear;

  assign req_code = reg_wdata[`CRN_REQ_CODE_W-1:0];
  assign req_code_ok = (req_code <= `CRN_REQ_CODE_LAST);

  // Decoded combinationally so the channel clears on the write edge.
  always @* begin
    chan_clear = {`CRN_WAKE_CNT{1'b0}};
    if (wr_req_clear && req_code_ok) begin
      chan_clear[req_code[2:0]] = 1'b1;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `CRN_WAKE_CNT; ch = ch + 1) begin : g_chan
      // Each input owns a fixed three-bit mode slice and a two-bit
      // edge-status slice; modes 5 to 7 never raise a request.
      wire [2:0] chan_mode;
      assign chan_mode = ext_int_mode[3*ch+2:3*ch];
      crn_wake_chan u_chan (
        .clk(clk),
        .arst_n(arst_n),
        .pin_level(int_level[ch]),
        .enable(ext_int_enable[ch]),
        .mode(chan_mode),
        .clear(chan_clear[ch]),
        .pending(wake_pending[ch]),
        .edge_status(captured_edge_status[2*ch+1:2*ch])
      );
    end
  endgenerate

  assign standby_release = |wake_pending;

  // ----------------------------------------------------------------------
  // Reset-cause flags
  // ----------------------------------------------------------------------
  reg [`CRN_RC_W-1:0] cause_q;
  reg [`CRN_RC_W-1:0] cause_d;
  reg [`CRN_RC_W-1:0] cause_set;

  // Each cause input is a one-cycle pulse from the reset controller, except the pin event, which is detected here.
  always @* begin
    cause_set = {`CRN_RC_W{1'b0}};
    cause_set[`CRN_RC_LOWVOLT] = lowvolt_reset_evt;
    cause_set[`CRN_RC_SOFT] = soft_sysreset_evt;
    cause_set[`CRN_RC_WATCHDOG] = watchdog_reset_evt;
    cause_set[`CRN_RC_PIN] = pin_reset_evt;
  end

  // Flags only fall on a software zero; a cause arriving together with
  // that write still sets the flag.
  always @* begin
    cause_d = cause_q;
    if (wr_reset_cause) begin
      cause_d = cause_q & reg_wdata[`CRN_RC_W-1:0];
    end
    cause_d = (cause_d | cause_set) & `CRN_RC_IMPL_MASK;
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_q <= `CRN_RC_POR_VALUE;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------------------
  // NMI source flags
  // ----------------------------------------------------------------------
  // Read-only to software; the flags drop once they have been read so a
  // handler sees each source once. A source firing during that read stays.
  reg [`CRN_NMI_W-1:0] nmi_q;
  reg [`CRN_NMI_W-1:0] nmi_d;
  reg [`CRN_NMI_W-1:0] nmi_set;

  always @* begin
    nmi_set = {`CRN_NMI_W{1'b0}};
    nmi_set[`CRN_NMI_LV_RECOVER] = nmi_lowvolt_recover_evt;
    nmi_set[`CRN_NMI_LV_DROP] = nmi_lowvolt_drop_evt;
    nmi_set[`CRN_NMI_WATCHDOG] = nmi_watchdog_evt;
    if (rd_nmi_source) begin
      nmi_d = nmi_set;
    end else begin
      nmi_d = nmi_q | nmi_set;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_q <= {`CRN_NMI_W{1'b0}};
    end else begin
      nmi_q <= nmi_d;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------------
  reg [`CRN_IRQ_W-1:0] irq_stat_q;
  reg [`CRN_IRQ_W-1:0] irq_mask_q;
  reg [`CRN_WAKE_CNT-1:0] wake_prev_q;
  wire [`CRN_IRQ_W-1:0] irq_set;
  reg [`CRN_IRQ_W-1:0] irq_clr;

  assign irq_set = {nmi_lowvolt_recover_evt,
                    nmi_lowvolt_drop_evt,
                    nmi_watchdog_evt,
                    wake_pending & ~wake_prev_q};
  always @* begin
    irq_clr = {`CRN_IRQ_W{1'b0}};
    if (wr_irq_status) begin
      irq_clr = reg_wdata[`CRN_IRQ_W-1:0];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= {`CRN_IRQ_W{1'b0}};
      irq_mask_q <= `CRN_IRQ_MASK_RESET;
      wake_prev_q <= {`CRN_WAKE_CNT{1'b0}};
    end else begin
      // An event in the clear cycle wins, so none is lost.
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      wake_prev_q <= wake_pending;
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wdata[`CRN_IRQ_W-1:0];
      end
    end
  end

  // The mask only gates the output; status keeps collecting events while
  // masked, so software can still poll it.
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // The request-clear register is write-only and reads as zero, as does
  // any unmapped offset.
  always @* begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `CRN_OFF_RESET_CAUSE: begin
          rdata_d[`CRN_RC_W-1:0] = cause_q;
        end
        `CRN_OFF_NMI_SOURCE: begin
          rdata_d[`CRN_NMI_W-1:0] = nmi_q;
        end
        `CRN_OFF_IRQ_STATUS: begin
          rdata_d[`CRN_IRQ_W-1:0] = irq_stat_q;
        end
        `CRN_OFF_IRQ_MASK: begin
          rdata_d[`CRN_IRQ_W-1:0] = irq_mask_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // crn_reset_nmi_regs

// File: crn_reset_nmi_asserts.sv
// Port-level checks of the reset-cause and NMI register bank.
// Assumes one clock domain with arst_n as the only reset.
`timescale 1ns/1ps

module crn_reset_nmi_asserts (
  input wire clk,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire watchdog_reset_evt,
  input wire lowvolt_reset_evt,
  input wire soft_sysreset_evt,
  input wire nmi_watchdog_evt,
  input wire nmi_lowvolt_drop_evt,
  input wire nmi_lowvolt_recover_evt,
  input wire [17:0] ext_int_mode,
  input wire [5:0] wake_pending,
  input wire [11:0] captured_edge_status
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire rd_rc = reg_rd && reg_addr == 8'h04;
  wire rd_nmi = reg_rd && reg_addr == 8'h08;
  wire wr_clr = reg_wr && reg_addr == 8'h00;
  wire [2:0] sel = reg_wdata[2:0];
  // Level modes may legally re-set a cleared request, so only edge
  // modes are held to the clear.
  wire [2:0] sel_mode = ext_int_mode[3 * sel +: 3];
  reg [2:0] sel_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      sel_q <= 3'h0;
    else
      sel_q <= sel;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_rc_rsvd: assert property (
    rd_rc |=> (reg_rdata & ~32'h57) == 32'h0)
    else $error("reserved reset-cause bit set");
  a_wdog_cause: assert property (
    watchdog_reset_evt ##1 !reg_wr ##1 rd_rc |=> reg_rdata[2])
    else $error("watchdog reset cause missing");
  a_soft_cause: assert property (
    soft_sysreset_evt ##1 !reg_wr ##1 rd_rc |=> reg_rdata[4])
    else $error("soft reset cause missing");
  a_lowvolt_cause: assert property (
    lowvolt_reset_evt ##1 !reg_wr ##1 rd_rc |=> reg_rdata[6])
    else $error("low-voltage reset cause missing");
  a_nmi_wdog: assert property (
    nmi_watchdog_evt ##1 !reg_rd ##1 rd_nmi |=> reg_rdata[0])
    else $error("watchdog nmi flag missing");
  a_nmi_drop: assert property (
    nmi_lowvolt_drop_evt ##1 !reg_rd ##1 rd_nmi |=> reg_rdata[2])
    else $error("supply drop nmi flag missing");
  a_nmi_recover: assert property (
    nmi_lowvolt_recover_evt ##1 !reg_rd ##1 rd_nmi |=> reg_rdata[3])
    else $error("supply recovery nmi flag missing");
  a_clr_pend: assert property (
    wr_clr && reg_wdata[4:0] <= 5'h05 && sel_mode >= 3'h2 &&
    sel_mode <= 3'h4 |=> !wake_pending[sel_q] &&
    captured_edge_status[2 * sel_q +: 2] == 2'h0)
    else $error("request clear did not clear");
  a_bad_code: assert property (
    wr_clr && reg_wdata[4:0] > 5'h05 |=>
    ($past(wake_pending) & ~wake_pending) == 6'h0)
    else $error("prohibited code cleared a request");
endmodule // crn_reset_nmi_asserts

bind crn_reset_nmi_regs crn_reset_nmi_asserts u_chk (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .watchdog_reset_evt(watchdog_reset_evt),
  .lowvolt_reset_evt(lowvolt_reset_evt),
  .soft_sysreset_evt(soft_sysreset_evt),
  .nmi_watchdog_evt(nmi_watchdog_evt),
  .nmi_lowvolt_drop_evt(nmi_lowvolt_drop_evt),
  .nmi_lowvolt_recover_evt(nmi_lowvolt_recover_evt),
  .ext_int_mode(ext_int_mode), .wake_pending(wake_pending),
  .captured_edge_status(captured_edge_status)
);

// File: test_crn_reset_nmi_regs.sv
// Self-checking bench of the reset-cause and NMI register bank.
// Assumes the design and its map header are compiled before it.
`timescale 1ns/1ps

module test_crn_reset_nmi_regs;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg pin_n = 1'b1;
  reg [5:0] ev = 6'h00;
  reg [5:0] pins = 6'h00;
  reg [5:0] en = 6'h00;
  reg [17:0] mode = 18'h0;
  wire [31:0] rdata;
  wire [5:0] pend;
  wire [11:0] est;
  wire irq;
  wire sby;
  integer miscompares = 0;
  integer tests_run = 0;
  integer i;
  reg [31:0] exp;

  crn_reset_nmi_regs dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
    .reset_pin_n(pin_n), .watchdog_reset_evt(ev[0]),
    .soft_sysreset_evt(ev[1]), .lowvolt_reset_evt(ev[2]),
    .nmi_watchdog_evt(ev[3]), .nmi_lowvolt_drop_evt(ev[4]),
    .nmi_lowvolt_recover_evt(ev[5]), .ext_int_pin(pins),
    .ext_int_enable(en), .ext_int_mode(mode), .wake_pending(pend),
    .captured_edge_status(est), .standby_release(sby), .irq(irq)
  );

  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
    end
  endtask
  task rdchk(input string nm, input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(nm, e, rdata);
    end
  endtask
  task pulse(input integer n);
    begin
      @(posedge clk);
      ev[n] <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
      #1;
    end
  endtask
  // Pins pass a synchroniser first, so the wait is bounded, not fixed.
  task wait_pend(input integer n);
    integer k;
    begin
      k = 0;
      while (pend[n] !== 1'b1 && k < 20) begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
      chk("pend", 32'h1 << n, {26'h0, pend});
      chk("sby", 32'h1, {31'h0, sby});
    end
  endtask
  // The mode goes in with the input disabled; the enable follows one
  // cycle later, never in the same cycle.
  task set_mode(input integer c, input [2:0] m);
    begin
      @(posedge clk);
      en[c] <= 1'b0;
      mode[3*c +: 3] <= m;
      @(posedge clk);
      en[c] <= 1'b1;
    end
  endtask

  initial begin
    #200000;
    miscompares = miscompares + 1;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdchk("rc_por", 8'h04, 32'h01);
    rdchk("nmi_por", 8'h08, 32'h0);
    rdchk("clr_rd", 8'h00, 32'h0);
    rdchk("mask_por", 8'h10, 32'h0);
    wr(8'h14, 32'hffffffff);
    rdchk("unmapped", 8'h14, 32'h0);
    exp = 32'h01;
    for (i = 0; i < 3; i = i + 1) begin
      pulse(i);
      exp = exp | (32'h4 << (2 * i));
      rdchk("rc_evt", 8'h04, exp);
    end
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    rdchk("rc_pin", 8'h04, 32'h57);
    wr(8'h04, 32'hffffffff);
    rdchk("rc_keep", 8'h04, 32'h57);
    repeat (50) @(posedge clk);
    rdchk("rc_stay", 8'h04, 32'h57);
    wr(8'h04, 32'hfffffffb);
    rdchk("rc_clr1", 8'h04, 32'h53);
    wr(8'h04, 32'h0);
    rdchk("rc_clr", 8'h04, 32'h0);
    for (i = 3; i < 6; i = i + 1) begin
      pulse(i);
      exp = (i == 3) ? 32'h1 : (32'h1 << (i - 2));
      rdchk("nmi", 8'h08, exp);
      rdchk("nmi_rd", 8'h08, 32'h0);
    end
    wr(8'h0c, 32'h1ff);
    wr(8'h10, 32'h040);
    chk("irq_off", 32'h0, {31'h0, irq});
    pulse(3);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(8'h0c, 32'h040);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    wr(8'h10, 32'h0);
    pulse(3);
    chk("irq_mask", 32'h0, {31'h0, irq});
    rdchk("irq_st", 8'h0c, 32'h040);
    // Edge mode goes in before the enable, never together.
    @(posedge clk);
    mode <= {6{3'h3}};
    @(posedge clk);
    en <= 6'h3f;
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk);
      pins[i] <= 1'b1;
      wait_pend(i);
      wr(8'h00, 6 + 5 * i);
      chk("pend_bad", 32'h1 << i, {26'h0, pend});
      wr(8'h00, i);
      chk("pend_clr", 32'h0, {26'h0, pend});
    end
    @(posedge clk);
    mode[2:0] <= 3'h4;
    @(posedge clk);
    pins[0] <= 1'b0;
    wait_pend(0);
    chk("edge", 32'h2, {20'h0, est});
    wr(8'h00, 32'h0);
    chk("edge_clr", 32'h0, {20'h0, est});
    chk("pend_end", 32'h0, {26'h0, pend});
    chk("sby_end", 32'h0, {31'h0, sby});
    // Falling edge on input 1.
    set_mode(1, 3'h2);
    pins[1] <= 1'b0;
    wait_pend(1);
    wr(8'h00, 32'h1);
    chk("pend_fall", 32'h0, {26'h0, pend});
    // High level on input 2, low level on input 3: a clear while the
    // level is active does not stick.
    for (i = 2; i < 4; i = i + 1) begin
      set_mode(i, (i == 2) ? 3'h1 : 3'h0);
      pins[i] <= (i == 2);
      wait_pend(i);
      wr(8'h00, i);
      chk("pend_lvl", 32'h1 << i, {26'h0, pend});
      @(posedge clk);
      pins[i] <= (i != 2);
      repeat (6) @(posedge clk);
      wr(8'h00, i);
      chk("pend_idle", 32'h0, {26'h0, pend});
    end
    // An unused mode code never raises a request.
    set_mode(4, 3'h5);
    pins[4] <= 1'b0;
    repeat (8) @(posedge clk);
    pins[4] <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("pend_off", 32'h0, {26'h0, pend});
    chk("sby_off", 32'h0, {31'h0, sby});
    rdchk("irq_wake", 8'h0c, 32'h07f);
    give_verdict;
  end
endmodule // test_crn_reset_nmi_regs
